/* File: tspl_top.sv */
// tamper supervisor pin logic: alarm, reset, power-fail, supply switching
`timescale 1ns/1ns
module tspl_top #(
    parameter tspl_pkg::tspl_variant_t VARIANT = tspl_pkg::TSPL_VAR_KEEP_ON,
    parameter int TIMEOUT_CYC = tspl_pkg::TSPL_TIMEOUT_CYC
) (
    input wire logic i_core_clk, // core clock
    input wire logic i_srst, // sync reset, high
    input wire logic i_vint_over, // supply above over_voltage_limit
    input wire logic i_vint_under, // supply below under_voltage_limit
    input wire logic i_tamper_in_one, // normally_high_sense
    input wire logic i_tamper_in_two, // normally_low_sense
    input wire logic i_tamper_in_three, // normally_high_sense
    input wire logic i_tamper_in_four, // normally_low_sense
    input wire logic i_temp_over, // above selected upper limit
    input wire logic i_temp_under, // below selected lower limit
    input wire logic i_vcc_below_rst, // main below reset_threshold
    input wire logic i_manual_reset_n, // manual reset, low active
    input wire logic i_power_fail_in, // input below power_fail_threshold
    input wire logic i_vcc_below_sw, // main below switchover_threshold
    input wire logic i_vcc_below_vbat, // main below battery
    input wire logic i_vcc_above_so, // main above backup_switchover_level
    input wire logic i_bat_below_det, // battery below battery_detect_threshold
    output logic o_security_alarm_n_oe, // open drain: high pulls pin low
    output logic o_reset_n_oe, // open drain reset pull-down
    output logic o_battery_low_n_oe, // open drain battery low
    output logic o_power_fail_out_n_oe, // open drain power fail
    output logic o_vccsw, // supply-source indicator
    output logic o_switched_supply_output_on_battery, // switched supply fed by battery
    output logic o_switched_supply_output_enable, // switched supply powered
    output logic o_switched_supply_output_ground, // switched supply grounded
    output logic o_ref_ground, // reference pin pulled to ground
    output logic o_ref_is_tpu // pin carries tamper_pullup_supply
);
    localparam int N = 14;
    logic [N-1:0] raw, s1, s2;
    assign raw = {i_vint_over, i_vint_under, i_tamper_in_four, i_tamper_in_three,
                  i_tamper_in_two, i_tamper_in_one, i_temp_over, i_temp_under,
                  i_vcc_below_rst, i_manual_reset_n, i_power_fail_in, i_vcc_below_sw,
                  i_vcc_below_vbat, i_vcc_above_so};
    // reset to idle levels so no false tamper or hold follows reset
    localparam logic [N-1:0] SYNC_RST = {2'h0, tspl_pkg::TSPL_TAMPER_REST, 8'h10};
    // two-stage synchroniser for all comparator and pin levels except battery detect, which has its own
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            s1 <= SYNC_RST;
            s2 <= SYNC_RST;
        end else begin
            s1 <= raw;
            s2 <= s1;
        end
    end
    logic v_over, v_under, t_over, t_under, vcc_low, mr_n, pfi_low;
    logic below_sw, below_vbat, above_so;
    logic [3:0] tamper;
    assign v_over = s2[13];
    assign v_under = s2[12];
    assign tamper = s2[11:8];
    assign t_over = s2[7];
    assign t_under = s2[6];
    assign vcc_low = s2[5];
    assign mr_n = s2[4];
    assign pfi_low = s2[3];
    assign below_sw = s2[2];
    assign below_vbat = s2[1];
    assign above_so = s2[0];

    ////////////////////////////////////////////////////////////////////////////
    // alarm
    logic [3:0] tamper_hit;
    logic alarm;
    assign tamper_hit = tamper ^ tspl_pkg::TSPL_TAMPER_REST;
    // level alarm, no latch: it follows conditions on main or battery
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            alarm <= 1'b0;
        end else begin
            alarm <= v_over | v_under | (|tamper_hit) | t_over | t_under;
        end
    end
    assign o_security_alarm_n_oe = alarm;

    ////////////////////////////////////////////////////////////////////////////
    // supply switching
    logic on_bat;
    // hysteresis: enter battery below min(sw,vbat), leave only above so
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            on_bat <= 1'b0;
        end else if (below_sw && below_vbat) begin
            on_bat <= 1'b1;
        end else if (above_so) begin
            on_bat <= 1'b0;
        end
    end
    logic alarm_cut;
    assign alarm_cut = alarm && (VARIANT != tspl_pkg::TSPL_VAR_KEEP_ON);
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_vccsw <= 1'b0;
            o_switched_supply_output_on_battery <= 1'b0;
            o_switched_supply_output_enable <= 1'b1;
            o_switched_supply_output_ground <= 1'b0;
        end else begin
            o_vccsw <= on_bat | alarm_cut;
            o_switched_supply_output_on_battery <= on_bat;
            o_switched_supply_output_enable <= !alarm_cut;
            o_switched_supply_output_ground <= alarm && (VARIANT == tspl_pkg::TSPL_VAR_GROUND);
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_ref_ground <= 1'b0;
            o_ref_is_tpu <= 1'b0;
        end else begin
            o_ref_ground <= (VARIANT == tspl_pkg::TSPL_VAR_KEEP_ON) && below_sw;
            o_ref_is_tpu <= VARIANT != tspl_pkg::TSPL_VAR_KEEP_ON;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power fail
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            o_power_fail_out_n_oe <= 1'b1;
        end else begin
            o_power_fail_out_n_oe <= pfi_low | below_sw;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // supervisory reset
    tspl_pkg::tspl_rst_state_t st, next_st;
    logic [tspl_pkg::TSPL_CNT_W-1:0] cnt;
    logic hold;
    assign hold = vcc_low | !mr_n;
    always_comb begin
        next_st = st;
        unique case (st)
            tspl_pkg::TSPL_RST_HOLD: if (!hold) next_st = tspl_pkg::TSPL_RST_COUNT;
            tspl_pkg::TSPL_RST_COUNT: begin
                if (hold) next_st = tspl_pkg::TSPL_RST_HOLD;
                else if (cnt == tspl_pkg::TSPL_CNT_W'(TIMEOUT_CYC - 1)) begin
                    next_st = tspl_pkg::TSPL_RST_RUN;
                end
            end
            tspl_pkg::TSPL_RST_RUN: if (hold) next_st = tspl_pkg::TSPL_RST_HOLD;
            default: next_st = tspl_pkg::TSPL_RST_HOLD;
        endcase
    end
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            st <= tspl_pkg::TSPL_RST_HOLD;
        end else begin
            st <= next_st;
        end
    end
    // counter clears whenever reset is held, restarts on release
    always_ff @(posedge i_core_clk) begin
        if (i_srst || st != tspl_pkg::TSPL_RST_COUNT || hold) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
    assign o_reset_n_oe = (st != tspl_pkg::TSPL_RST_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // battery low: sampled once per power-up, released by reset threshold
    logic bat_checked;
    logic bd1, i_bat_below_det_s;
    always_ff @(posedge i_core_clk) begin
        if (i_srst || vcc_low) begin
            bat_checked <= 1'b0;
            o_battery_low_n_oe <= 1'b0;
        end else if (!bat_checked) begin
            bat_checked <= 1'b1;
            o_battery_low_n_oe <= i_bat_below_det_s;
        end
    end
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            bd1 <= 1'b0;
            i_bat_below_det_s <= 1'b0;
        end else begin
            bd1 <= i_bat_below_det;
            i_bat_below_det_s <= bd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_released;
        !hold ##1 !hold;
    endsequence
    sequence s_bat_enter;
        below_sw && below_vbat;
    endsequence
    sequence s_bat_stay;
        !(below_sw && below_vbat) && !above_so;
    endsequence

    // cycles since hold last fell, saturating; an independent model of the
    // minimum reset width, so the counter is not checked against itself
    logic [tspl_pkg::TSPL_CNT_W-1:0] rel_cnt;
    always_ff @(posedge i_core_clk) begin
        if (i_srst || hold) begin
            rel_cnt <= '0;
        end else if (rel_cnt != '1) begin
            rel_cnt <= rel_cnt + 1'b1;
        end
    end

    // alarm causes, each on its own
    a_alarm_tamper: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (|tamper_hit) |=> alarm) else $error("tamper did not raise alarm");
    a_alarm_clear: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (!v_over && !v_under && tamper_hit == 4'h0 && !t_over && !t_under) |=> !alarm)
        else $error("alarm without cause");
    a_alarm_vover: assert property (@(posedge i_core_clk) disable iff (i_srst)
        v_over |=> alarm)
        else $error("over-voltage did not raise alarm");
    a_alarm_vunder: assert property (@(posedge i_core_clk) disable iff (i_srst)
        v_under |=> alarm)
        else $error("under-voltage did not raise alarm");
    a_alarm_tover: assert property (@(posedge i_core_clk) disable iff (i_srst)
        t_over |=> alarm)
        else $error("over-temperature did not raise alarm");
    a_alarm_tunder: assert property (@(posedge i_core_clk) disable iff (i_srst)
        t_under |=> alarm)
        else $error("under-temperature did not raise alarm");
    a_tamper_high: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (!tamper[0] || !tamper[2]) |=> alarm)
        else $error("high-rest tamper pulled low missed");
    a_tamper_low: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (tamper[1] || tamper[3]) |=> alarm)
        else $error("low-rest tamper pulled high missed");
    a_alarm_battery: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (on_bat && (v_over || v_under)) |=> alarm)
        else $error("alarm lost on battery");

    // supervisory reset
    a_reset_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
        hold |=> o_reset_n_oe) else $error("reset released while held");
    a_reset_min: assert property (@(posedge i_core_clk) disable iff (i_srst)
        ($fell(hold) ##0 s_released) |-> o_reset_n_oe) else $error("reset released early");
    a_cnt_clear: assert property (@(posedge i_core_clk) disable iff (i_srst)
        vcc_low |=> cnt == '0) else $error("time-out counter not cleared");
    a_mr_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !mr_n |=> o_reset_n_oe)
        else $error("manual reset did not hold reset");
    a_reset_width: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !o_reset_n_oe |-> (rel_cnt > tspl_pkg::TSPL_CNT_W'(TIMEOUT_CYC)))
        else $error("reset shorter than time-out");
    a_reset_run: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (st == tspl_pkg::TSPL_RST_RUN && !hold) |=> !o_reset_n_oe)
        else $error("reset asserted without cause");
    a_run_entry: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (st == tspl_pkg::TSPL_RST_COUNT && !hold && cnt == tspl_pkg::TSPL_CNT_W'(TIMEOUT_CYC - 1)) |=> !o_reset_n_oe)
        else $error("reset not released after time-out");
    a_hold_exit: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (st == tspl_pkg::TSPL_RST_HOLD && !hold) |=> st == tspl_pkg::TSPL_RST_COUNT)
        else $error("time-out did not start");
    a_hold_state: assert property (@(posedge i_core_clk) disable iff (i_srst)
        st == tspl_pkg::TSPL_RST_HOLD |-> o_reset_n_oe)
        else $error("reset low in hold");
    a_count_state: assert property (@(posedge i_core_clk) disable iff (i_srst)
        st == tspl_pkg::TSPL_RST_COUNT |-> o_reset_n_oe)
        else $error("reset low while counting");
    a_cnt_track: assert property (@(posedge i_core_clk) disable iff (i_srst)
        st == tspl_pkg::TSPL_RST_COUNT |-> cnt == rel_cnt - 1'b1)
        else $error("time-out count off its start");
    a_cnt_idle: assert property (@(posedge i_core_clk) disable iff (i_srst)
        st != tspl_pkg::TSPL_RST_COUNT |=> cnt == '0)
        else $error("time-out counter runs outside count");

    // power fail and reference pin
    a_pfo_level: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (pfi_low || below_sw) |=> o_power_fail_out_n_oe) else $error("power fail missed");
    a_pfo_clear: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (!pfi_low && !below_sw) |=> !o_power_fail_out_n_oe)
        else $error("power fail without cause");
    a_ref_ground: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (VARIANT == tspl_pkg::TSPL_VAR_KEEP_ON && below_sw) |=> o_ref_ground)
        else $error("reference not grounded");
    a_ref_release: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !below_sw |=> !o_ref_ground)
        else $error("reference grounded on good supply");
    a_ref_tpu: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (VARIANT != tspl_pkg::TSPL_VAR_KEEP_ON) |=> o_ref_is_tpu && !o_ref_ground)
        else $error("pull-up supply pin wrong");

    // supply source and switched output
    a_vccsw_cut: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (alarm && VARIANT != tspl_pkg::TSPL_VAR_KEEP_ON) |=> o_vccsw && !o_switched_supply_output_enable)
        else $error("indicator not forced on alarm");
    a_source_main: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (!on_bat && !alarm_cut) |=> !o_vccsw) else $error("indicator high on main");
    a_source_bat: assert property (@(posedge i_core_clk) disable iff (i_srst)
        on_bat |=> o_vccsw)
        else $error("indicator low on battery");
    a_bat_enter: assert property (@(posedge i_core_clk) disable iff (i_srst)
        s_bat_enter |=> on_bat)
        else $error("battery not switched in");
    a_bat_leave: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (!(below_sw && below_vbat) && above_so) |=> !on_bat)
        else $error("main not switched back");
    a_bat_stay: assert property (@(posedge i_core_clk) disable iff (i_srst)
        s_bat_stay |=> $stable(on_bat))
        else $error("source moved inside hysteresis");
    a_switched_supply_output_bat: assert property (@(posedge i_core_clk) disable iff (i_srst)
        on_bat |=> o_switched_supply_output_on_battery)
        else $error("output not fed by battery");
    a_switched_supply_output_main: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !on_bat |=> !o_switched_supply_output_on_battery)
        else $error("output not fed by main");
    a_switched_supply_output_kept: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (VARIANT == tspl_pkg::TSPL_VAR_KEEP_ON) |=> o_switched_supply_output_enable && !o_switched_supply_output_ground)
        else $error("keep-on output cut");
    a_vccsw_keep: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (VARIANT == tspl_pkg::TSPL_VAR_KEEP_ON) |=> o_vccsw == $past(on_bat))
        else $error("keep-on indicator not normal");
    a_switched_supply_output_ground: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (alarm && VARIANT == tspl_pkg::TSPL_VAR_GROUND) |=> o_switched_supply_output_ground)
        else $error("output not grounded on alarm");
    a_switched_supply_output_float: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (alarm && VARIANT == tspl_pkg::TSPL_VAR_HIGH_Z) |=> !o_switched_supply_output_enable && !o_switched_supply_output_ground)
        else $error("output not floated on alarm");
    a_ground_only: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !alarm |=> o_switched_supply_output_enable && !o_switched_supply_output_ground)
        else $error("output cut without alarm");

    // battery low
    a_bld_release: assert property (@(posedge i_core_clk) disable iff (i_srst)
        vcc_low |=> !o_battery_low_n_oe) else $error("battery low not released");
    a_bld_sample: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (!bat_checked && !vcc_low) |=> o_battery_low_n_oe == $past(i_bat_below_det_s))
        else $error("battery check sampled wrong level");
    a_bld_set: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (!bat_checked && !vcc_low && i_bat_below_det_s) |=> o_battery_low_n_oe)
        else $error("low battery not flagged");
    a_bld_once: assert property (@(posedge i_core_clk) disable iff (i_srst)
        (bat_checked && !vcc_low) |=> $stable(o_battery_low_n_oe))
        else $error("battery checked outside power-up");
    a_bld_rearm: assert property (@(posedge i_core_clk) disable iff (i_srst)
        vcc_low |=> !bat_checked)
        else $error("battery check not rearmed");
endmodule : tspl_top

/* File: tspl_pkg.sv */
// constants and types for the tamper supervisor pin logic
// Notes on behaviour
// - alarm when supply above upper trip limit
// - alarm when supply below lower trip limit
// - alarm when any tamper input leaves rest
// - alarm above factory upper temperature limit
// - alarm below factory lower temperature limit
// - alarm level at power-up is undefined
// - detection works on main or battery
// - tamper one and three rest high
// - tamper two and four rest low
// - source indicator low main, high battery
// - keep-on variant keeps output, normal indicator
// - float or ground variants force indicator high on alarm
// - battery check only during power-up
// - battery low set below threshold, released at reset
// - reset held low, then time-out after clear
// - manual reset low extends reset plus time-out
// - power-fail low on input or switchover fault
// - keep-on variant grounds reference below switchover; float and ground variants give pull-up supply
// - output fed from main or battery by switchover
// - time-out counter clears while supply low
package tspl_pkg;
    typedef enum logic [1:0] {
        TSPL_VAR_KEEP_ON = 2'h0,
        TSPL_VAR_HIGH_Z = 2'h1,
        TSPL_VAR_GROUND = 2'h3
    } tspl_variant_t;

    typedef enum logic [1:0] {
        TSPL_RST_HOLD = 2'h0,
        TSPL_RST_COUNT = 2'h1,
        TSPL_RST_RUN = 2'h3
    } tspl_rst_state_t;

    localparam int TSPL_CLK_MHZ = 250;
    localparam int TSPL_TIMEOUT_MS = 200;
    localparam int TSPL_TIMEOUT_CYC = TSPL_TIMEOUT_MS * 1000 * TSPL_CLK_MHZ;
    localparam int TSPL_CNT_W = 26;
    localparam int TSPL_TAMPER_N = 4;
    // rest level per tamper input, bit0 = input one
    localparam logic [3:0] TSPL_TAMPER_REST = 4'h5;
endpackage : tspl_pkg

/* File: tspl_host.sv */
// host and enclosure switch model facing the tamper supervisor
`timescale 1ns/1ns
module tspl_host (
    input wire logic i_core_clk, // bench clock
    input wire logic [3:0] i_open, // switch opened, bit0 = input one
    input wire logic i_press, // push-button held
    output logic [3:0] o_tamper = 4'h5, // tamper lines, bit0 = input one
    output logic o_manual_reset_n = 1'b1 // manual reset line
);
    // one and three rest high, two and four rest low; opening flips the line
    always_ff @(posedge i_core_clk) begin
        o_tamper <= 4'h5 ^ i_open;
        o_manual_reset_n <= ~i_press;
    end
endmodule : tspl_host

/* File: tb_top.sv */
// self-checking bench for the tamper supervisor pin logic
`timescale 1ns/1ns
module tb_top;
    localparam int T = 12;
    typedef struct packed {
        logic [11:0] in;
        logic [4:0] ex;
    } tspl_row_t;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] st = 12'h080;
    logic below_rst = 1'b0;
    logic bat_low = 1'b0;
    logic press = 1'b0;
    logic [3:0] tp;
    logic mr_n;
    logic al, rs, bl, pf, vs, vb, ve, vg, rg, rt;
    logic [4:0] oz, og;
    int failures = 0;
    int samples_checked = 0;
    int n;
    // in: open[3:0], above_so, below_vbat, below_sw, pfi, t_under, t_over, v_under, v_over
    // ex: ref_ground, on_battery, vccsw, power_fail, alarm
    tspl_row_t rows [16] = '{'{12'h080, 5'h00}, '{12'h081, 5'h01}, '{12'h082, 5'h01},
        '{12'h084, 5'h01}, '{12'h088, 5'h01}, '{12'h090, 5'h02}, '{12'h180, 5'h01},
        '{12'h280, 5'h01}, '{12'h480, 5'h01}, '{12'h880, 5'h01}, '{12'h020, 5'h12},
        '{12'h060, 5'h1E}, '{12'h100, 5'h0D}, '{12'h080, 5'h00}, '{12'h040, 5'h00},
        '{12'h080, 5'h00}};

    always #2 clk = ~clk;

    tspl_host host (.i_core_clk(clk), .i_open(st[11:8]), .i_press(press), .o_tamper(tp),
        .o_manual_reset_n(mr_n));
    tspl_top #(.VARIANT(tspl_pkg::TSPL_VAR_KEEP_ON), .TIMEOUT_CYC(T)) dut (
        .i_core_clk(clk), .i_srst(srst), .i_vint_over(st[0]), .i_vint_under(st[1]),
        .i_tamper_in_one(tp[0]), .i_tamper_in_two(tp[1]), .i_tamper_in_three(tp[2]),
        .i_tamper_in_four(tp[3]), .i_temp_over(st[2]), .i_temp_under(st[3]),
        .i_vcc_below_rst(below_rst), .i_manual_reset_n(mr_n), .i_power_fail_in(st[4]),
        .i_vcc_below_sw(st[5]), .i_vcc_below_vbat(st[6]), .i_vcc_above_so(st[7]),
        .i_bat_below_det(bat_low), .o_security_alarm_n_oe(al), .o_reset_n_oe(rs),
        .o_battery_low_n_oe(bl), .o_power_fail_out_n_oe(pf), .o_vccsw(vs),
        .o_switched_supply_output_on_battery(vb), .o_switched_supply_output_enable(ve), .o_switched_supply_output_ground(vg),
        .o_ref_ground(rg), .o_ref_is_tpu(rt));
    // cut variants on the same stimulus: float and ground on alarm
    tspl_top #(.VARIANT(tspl_pkg::TSPL_VAR_HIGH_Z), .TIMEOUT_CYC(T)) dut_hz (
        .i_core_clk(clk), .i_srst(srst), .i_vint_over(st[0]), .i_vint_under(st[1]),
        .i_tamper_in_one(tp[0]), .i_tamper_in_two(tp[1]), .i_tamper_in_three(tp[2]),
        .i_tamper_in_four(tp[3]), .i_temp_over(st[2]), .i_temp_under(st[3]),
        .i_vcc_below_rst(below_rst), .i_manual_reset_n(mr_n), .i_power_fail_in(st[4]),
        .i_vcc_below_sw(st[5]), .i_vcc_below_vbat(st[6]), .i_vcc_above_so(st[7]),
        .i_bat_below_det(bat_low), .o_security_alarm_n_oe(), .o_reset_n_oe(),
        .o_battery_low_n_oe(), .o_power_fail_out_n_oe(), .o_vccsw(oz[0]),
        .o_switched_supply_output_on_battery(), .o_switched_supply_output_enable(oz[1]), .o_switched_supply_output_ground(oz[2]),
        .o_ref_ground(oz[4]), .o_ref_is_tpu(oz[3]));
    tspl_top #(.VARIANT(tspl_pkg::TSPL_VAR_GROUND), .TIMEOUT_CYC(T)) dut_gnd (
        .i_core_clk(clk), .i_srst(srst), .i_vint_over(st[0]), .i_vint_under(st[1]),
        .i_tamper_in_one(tp[0]), .i_tamper_in_two(tp[1]), .i_tamper_in_three(tp[2]),
        .i_tamper_in_four(tp[3]), .i_temp_over(st[2]), .i_temp_under(st[3]),
        .i_vcc_below_rst(below_rst), .i_manual_reset_n(mr_n), .i_power_fail_in(st[4]),
        .i_vcc_below_sw(st[5]), .i_vcc_below_vbat(st[6]), .i_vcc_above_so(st[7]),
        .i_bat_below_det(bat_low), .o_security_alarm_n_oe(), .o_reset_n_oe(),
        .o_battery_low_n_oe(), .o_power_fail_out_n_oe(), .o_vccsw(og[0]),
        .o_switched_supply_output_on_battery(), .o_switched_supply_output_enable(og[1]), .o_switched_supply_output_ground(og[2]),
        .o_ref_ground(og[4]), .o_ref_is_tpu(og[3]));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check

    // model flop plus two sync flops plus alarm and output registers
    task automatic settle();
        repeat (5) @(posedge clk);
        #1;
    endtask : settle

    // edges until reset lets go, bounded so a stuck reset cannot hang
    task automatic release_len(output int cnt);
        cnt = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (rs === 1'b1 && cnt < 64);
    endtask : release_len

    task automatic end_of_test();
        $display("checked %0d failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        failures++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check(rs, 1);
        release_len(n);
        check(n <= T + 7, 1);
        $display("power-up test done");
        foreach (rows[i]) begin
            @(posedge clk);
            st <= rows[i].in;
            settle();
            check({rg, vb, vs, pf, al}, rows[i].ex);
            check({ve, vg, rt}, 3'h4);
            check(oz, {2'h1, 1'b0, ~rows[i].ex[0], rows[i].ex[3] | rows[i].ex[0]});
            check(og, {2'h1, rows[i].ex[0], ~rows[i].ex[0], rows[i].ex[3] | rows[i].ex[0]});
        end
        $display("row tests done");
        @(posedge clk);
        below_rst <= 1'b1;
        bat_low <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check({bl, rs}, 2'h1);
        @(posedge clk);
        below_rst <= 1'b0;
        release_len(n);
        check(n >= T + 2 && n <= T + 7, 1);
        check(bl, 1);
        @(posedge clk);
        bat_low <= 1'b0;
        settle();
        check(bl, 1);
        $display("supply reset test done");
        // dip again mid count: the full period must restart
        @(posedge clk);
        below_rst <= 1'b1;
        repeat (4) @(posedge clk);
        below_rst <= 1'b0;
        repeat (T / 2) @(posedge clk);
        below_rst <= 1'b1;
        repeat (4) @(posedge clk);
        below_rst <= 1'b0;
        release_len(n);
        check(n >= T + 2 && n <= T + 7, 1);
        check(bl, 0);
        $display("counter clear test done");
        @(posedge clk);
        press <= 1'b1;
        repeat (T + 10) @(posedge clk);
        #1;
        check(rs, 1);
        @(posedge clk);
        press <= 1'b0;
        release_len(n);
        check(n >= T + 3 && n <= T + 8, 1);
        $display("manual reset test done");
        end_of_test();
    end
endmodule : tb_top
